// ===== shared/dmc_pkg.sv
// shared constants, types and helpers of the direct-mapped cache controller
package dmc_pkg;
    localparam int IDX_W    = 14;
    localparam int ENTRIES  = 16384;
    localparam int DATA_W   = 32;
    localparam int TAG_W    = 12;
    localparam int BE_W     = 4;
    localparam int WADDR_W  = 26;
    // field positions inside the word address (byte address bits 27:2)
    localparam int IDX_POS  = 0;
    localparam int TAG_POS  = 14;
    localparam int BIOS_POS = 15;
    localparam int BIOS_W   = 11;
    // 128K blocks holding the shadowed system firmware and its duplicate
    localparam logic [10:0] BIOS_BLK_LO = 11'h007;
    localparam logic [10:0] BIOS_BLK_HI = 11'h07F;
    // arbitration request positions
    localparam int REQ_REFRESH = 0;
    localparam int REQ_DMA     = 1;
    localparam int REQ_COP0    = 2;
    localparam int REQ_COP1    = 3;
    localparam int REQ_N       = 4;

    typedef logic [IDX_W-1:0]   dmc_idx_t;
    typedef logic [TAG_W-1:0]   dmc_tag_t;
    typedef logic [DATA_W-1:0]  dmc_word_t;
    typedef logic [WADDR_W-1:0] dmc_waddr_t;
    typedef logic [BE_W-1:0]    dmc_be_t;

    localparam dmc_idx_t  SWEEP_RST  = 14'h0000;
    localparam dmc_idx_t  SWEEP_LAST = 14'h3FFF;
    localparam dmc_be_t   BE_ALL_N   = 4'h0;
    localparam dmc_be_t   BE_NONE_N  = 4'hF;
    localparam dmc_word_t WORD_RST   = 32'h00000000;
    localparam dmc_waddr_t WADDR_RST = 26'h0000000;

    typedef enum logic [2:0] {ST_IDLE, ST_LOOK, ST_WPOST, ST_RMISS, ST_FILL, ST_SNOOP}
        dmc_state_t;
    typedef enum logic [2:0] {OWN_CPU, OWN_REFRESH, OWN_DMA, OWN_COP0, OWN_COP1}
        dmc_owner_t;

    function automatic dmc_tag_t tag_of(input dmc_waddr_t a);
        return a[TAG_POS +: TAG_W];
    endfunction

    function automatic dmc_idx_t idx_of(input dmc_waddr_t a);
        return a[IDX_POS +: IDX_W];
    endfunction

    function automatic logic in_bios(input dmc_waddr_t a);
        return (a[BIOS_POS +: BIOS_W] == BIOS_BLK_LO) || (a[BIOS_POS +: BIOS_W] == BIOS_BLK_HI);
    endfunction
endpackage

// ===== shared/dmc_mem_if.sv
// port between the cache controller and its data/tag store
`timescale 1ns/100ps
interface dmc_mem_if;
    import dmc_pkg::*;
    logic      en;
    dmc_idx_t  idx;
    dmc_be_t   byte_we;
    dmc_word_t wdata;
    logic      tag_we;
    logic      tag_valid;
    dmc_tag_t  wtag;
    dmc_word_t rdata;
    logic      rvalid;
    dmc_tag_t  rtag;

    modport ctrl (output en, idx, byte_we, wdata, tag_we, tag_valid, wtag,
                  input rdata, rvalid, rtag);
    modport store (input en, idx, byte_we, wdata, tag_we, tag_valid, wtag,
                   output rdata, rvalid, rtag);
endinterface

// ===== core/dmc_store.sv
// data store and tag store with registered read ports
`timescale 1ns/100ps
module dmc_store (
    // clock
    input wire logic clk,
    // controller side
    dmc_mem_if.store mem
);
    import dmc_pkg::*;

    dmc_word_t        data_mem [ENTRIES];
    logic [TAG_W:0]   tag_mem  [ENTRIES];
    dmc_word_t        rdata_q;
    logic [TAG_W:0]   rtag_q;

    // byte lanes written independently; a read in the same cycle returns the old word
    always_ff @(posedge clk) begin
        if (mem.en) begin
            for (int b = 0; b < BE_W; b++) begin
                if (mem.byte_we[b]) begin
                    data_mem[mem.idx][b*8 +: 8] <= mem.wdata[b*8 +: 8];
                end
            end
            rdata_q <= data_mem[mem.idx];
        end
    end

    always_ff @(posedge clk) begin
        if (mem.en) begin
            if (mem.tag_we) begin
                tag_mem[mem.idx] <= {mem.tag_valid, mem.wtag};
            end
            rtag_q <= tag_mem[mem.idx];
        end
    end

    assign mem.rdata  = rdata_q;
    assign mem.rvalid = rtag_q[TAG_W];
    assign mem.rtag   = rtag_q[TAG_W-1:0];
endmodule

// ===== core/dmc_cache_ctrl.sv
// processor bus cycle control, cache lookup/fill/update, expansion bus master and arbiter
`timescale 1ns/100ps
module dmc_cache_ctrl (
    // clock, reset, enable
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    // configuration
    input  wire logic                       cache_enable,
    input  wire logic                       shadow_bios,
    // processor bus
    input  wire logic [29:0]                cpu_addr,
    input  wire dmc_pkg::dmc_be_t           byte_lane_enables_n,
    input  wire logic                       address_strobe_n,
    input  wire logic                       cpu_mem_io,
    input  wire logic                       cpu_write,
    input  wire dmc_pkg::dmc_word_t         cpu_data_in,
    output dmc_pkg::dmc_word_t              cpu_data_out,
    output logic                            cpu_data_oe,
    output logic                            cycle_done_n,
    // expansion bus cycles of the processor
    output logic                            ext_req,
    output logic                            ext_write,
    output logic                            ext_mem_io,
    output dmc_pkg::dmc_waddr_t             ext_addr,
    output dmc_pkg::dmc_be_t                ext_be_n,
    output dmc_pkg::dmc_word_t              ext_wdata,
    input  wire dmc_pkg::dmc_word_t         ext_rdata,
    input  wire logic                       ext_done,
    // writes by other masters on the expansion bus
    input  wire logic                       snoop_write,
    input  wire dmc_pkg::dmc_waddr_t        snoop_addr,
    input  wire dmc_pkg::dmc_be_t           snoop_be_n,
    input  wire dmc_pkg::dmc_word_t         snoop_data,
    // arbitration
    input  wire logic [3:0]                 bus_req,
    output logic [3:0]                      bus_grant,
    output logic                            cpu_owns_bus,
    // buffer steering
    output logic                            abuf_to_ext_oe,
    output logic                            abuf_to_cpu_oe,
    output logic                            dbuf_to_ext_oe,
    output logic                            dbuf_to_cpu_oe,
    // status
    output logic                            sweep_busy
);
    import dmc_pkg::*;

    dmc_mem_if mif ();

    dmc_store u_store (
        .clk (clk),
        .mem (mif)
    );

    // processor bus clock is half the input clock
    logic        phase_q;
    logic        tick;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q <= 1'b0;
        end else if (ce) begin
            phase_q <= ~phase_q;
        end
    end

    assign tick = ce & phase_q;

    // valid sweep after reset clears every entry
    logic        sweep_busy_q;
    dmc_idx_t    sweep_idx_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sweep_busy_q <= 1'b1;
            sweep_idx_q  <= SWEEP_RST;
        end else if (ce && sweep_busy_q) begin
            sweep_idx_q <= sweep_idx_q + 14'h0001;
            if (sweep_idx_q == SWEEP_LAST) begin
                sweep_busy_q <= 1'b0;
            end
        end
    end

    assign sweep_busy = sweep_busy_q;

    dmc_state_t  state_q;
    dmc_owner_t  owner_q;
    dmc_owner_t  owner_pick;
    dmc_waddr_t  req_addr_q;
    dmc_be_t     req_be_n_q;
    logic        req_write_q;
    logic        req_mem_q;
    logic        snp_pend_q;
    dmc_waddr_t  snp_addr_q;
    dmc_be_t     snp_be_n_q;
    dmc_word_t   snp_data_q;
    logic        ext_req_q;
    logic        ext_write_q;
    logic        ext_mem_io_q;
    dmc_waddr_t  ext_addr_q;
    dmc_be_t     ext_be_n_q;
    dmc_word_t   ext_wdata_q;
    logic        back_q;
    dmc_word_t   back_data_q;

    // lookup results
    dmc_waddr_t  look_addr;
    logic        tag_match;
    logic        cacheable;
    logic        rd_hit;
    logic        wr_hit;
    logic        snp_hit;
    logic        fill_ok;
    logic        bus_free;
    logic        launch;
    logic        cpu_need;
    logic        owner_idle;
    logic        done;

    assign look_addr = (state_q == ST_SNOOP) ? snp_addr_q : req_addr_q;
    assign tag_match = !sweep_busy_q && mif.rvalid
                       && (mif.rtag == tag_of(look_addr));
    assign cacheable = cache_enable && req_mem_q
                       && !(shadow_bios && in_bios(req_addr_q));
    assign rd_hit    = !req_write_q && cacheable && tag_match;
    assign wr_hit    = req_write_q && req_mem_q && cache_enable && tag_match;
    assign snp_hit   = cache_enable && tag_match;
    assign fill_ok   = cacheable && !sweep_busy_q;
    assign bus_free  = (owner_q == OWN_CPU) && !ext_req_q;
    assign launch    = tick && bus_free && (state_q == ST_WPOST || state_q == ST_RMISS);

    // cycle tracking
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            req_addr_q  <= WADDR_RST;
            req_be_n_q  <= BE_NONE_N;
            req_write_q <= 1'b0;
            req_mem_q   <= 1'b0;
        end else if (tick) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (!address_strobe_n) begin
                        req_addr_q  <= cpu_addr[WADDR_W-1:0];
                        req_be_n_q  <= byte_lane_enables_n;
                        req_write_q <= cpu_write;
                        req_mem_q   <= cpu_mem_io;
                        state_q     <= ST_LOOK;
                    end else if (snp_pend_q) begin
                        state_q <= ST_SNOOP;
                    end
                end
                ST_LOOK: begin
                    if (req_write_q) begin
                        state_q <= ST_WPOST;
                    end else if (rd_hit) begin
                        state_q <= ST_IDLE;
                    end else begin
                        state_q <= ST_RMISS;
                    end
                end
                ST_WPOST: begin
                    if (bus_free) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_RMISS: begin
                    if (bus_free) begin
                        state_q <= ST_FILL;
                    end
                end
                ST_FILL: begin
                    if (back_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_SNOOP: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // one-deep hold of another master's write; a new write wins over the clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            snp_pend_q <= 1'b0;
            snp_addr_q <= WADDR_RST;
            snp_be_n_q <= BE_NONE_N;
            snp_data_q <= WORD_RST;
        end else if (ce) begin
            if (snoop_write) begin
                snp_pend_q <= 1'b1;
                snp_addr_q <= snoop_addr;
                snp_be_n_q <= snoop_be_n;
                snp_data_q <= snoop_data;
            end else if (tick && state_q == ST_SNOOP) begin
                snp_pend_q <= 1'b0;
            end
        end
    end

    // expansion bus cycle engine; the request stands until ext_done
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_req_q    <= 1'b0;
            ext_write_q  <= 1'b0;
            ext_mem_io_q <= 1'b0;
            ext_addr_q   <= WADDR_RST;
            ext_be_n_q   <= BE_NONE_N;
            ext_wdata_q  <= WORD_RST;
        end else if (ce) begin
            if (launch) begin
                ext_req_q    <= 1'b1;
                ext_write_q  <= req_write_q;
                ext_mem_io_q <= req_mem_q;
                ext_addr_q   <= req_addr_q;
                ext_be_n_q   <= (fill_ok && !req_write_q) ? BE_ALL_N : req_be_n_q;
                ext_wdata_q  <= cpu_data_in;
            end else if (ext_done) begin
                ext_req_q <= 1'b0;
            end
        end
    end

    // returned read data, held until the processor cycle ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            back_q      <= 1'b0;
            back_data_q <= WORD_RST;
        end else if (ce) begin
            if (ext_done && ext_req_q && !ext_write_q) begin
                back_q      <= 1'b1;
                back_data_q <= ext_rdata;
            end else if (tick && state_q == ST_FILL) begin
                back_q <= 1'b0;
            end
        end
    end

    // store port
    always_comb begin
        mif.en        = ce;
        mif.idx       = sweep_busy_q ? sweep_idx_q : idx_of(look_addr);
        mif.byte_we   = 4'h0;
        mif.wdata     = cpu_data_in;
        mif.tag_we    = 1'b0;
        mif.tag_valid = 1'b1;
        mif.wtag      = tag_of(req_addr_q);
        if (sweep_busy_q) begin
            mif.tag_we    = 1'b1;
            mif.tag_valid = 1'b0;
        end else if (tick && state_q == ST_LOOK && wr_hit) begin
            mif.byte_we = ~req_be_n_q;
        end else if (tick && state_q == ST_FILL && back_q && fill_ok) begin
            mif.byte_we = 4'hF;
            mif.wdata   = back_data_q;
            mif.tag_we  = 1'b1;
        end else if (tick && state_q == ST_SNOOP && snp_hit) begin
            mif.byte_we = ~snp_be_n_q;
            mif.wdata   = snp_data_q;
        end
    end

    // cycle done: the processor samples it on the bus clock edge
    assign done = (state_q == ST_LOOK && rd_hit)
                  || (state_q == ST_WPOST && bus_free)
                  || (state_q == ST_FILL && back_q);
    assign cycle_done_n = ~done;

    assign cpu_data_out = (state_q == ST_FILL) ? back_data_q : mif.rdata;
    assign cpu_data_oe  = !req_write_q && ((state_q == ST_LOOK && req_mem_q)
                          || (state_q == ST_FILL && back_q));

    // arbiter: fixed priority, owner changes only when its current user lets go
    assign cpu_need = (state_q == ST_WPOST) || (state_q == ST_RMISS) || ext_req_q;

    always_comb begin
        if (bus_req[REQ_REFRESH]) begin
            owner_pick = OWN_REFRESH;
        end else if (bus_req[REQ_DMA]) begin
            owner_pick = OWN_DMA;
        end else if (bus_req[REQ_COP0]) begin
            owner_pick = OWN_COP0;
        end else if (bus_req[REQ_COP1]) begin
            owner_pick = OWN_COP1;
        end else begin
            owner_pick = OWN_CPU;
        end
    end

    always_comb begin
        unique case (owner_q)
            OWN_CPU:     owner_idle = !cpu_need;
            OWN_REFRESH: owner_idle = !bus_req[REQ_REFRESH];
            OWN_DMA:     owner_idle = !bus_req[REQ_DMA];
            OWN_COP0:    owner_idle = !bus_req[REQ_COP0];
            OWN_COP1:    owner_idle = !bus_req[REQ_COP1];
            default:     owner_idle = 1'b1;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            owner_q <= OWN_CPU;
        end else if (ce && owner_idle) begin
            owner_q <= owner_pick;
        end
    end

    assign bus_grant[REQ_REFRESH] = (owner_q == OWN_REFRESH);
    assign bus_grant[REQ_DMA]     = (owner_q == OWN_DMA);
    assign bus_grant[REQ_COP0]    = (owner_q == OWN_COP0);
    assign bus_grant[REQ_COP1]    = (owner_q == OWN_COP1);
    assign cpu_owns_bus           = (owner_q == OWN_CPU);

    assign ext_req    = ext_req_q;
    assign ext_write  = ext_write_q;
    assign ext_mem_io = ext_mem_io_q;
    assign ext_addr   = ext_addr_q;
    assign ext_be_n   = ext_be_n_q;
    assign ext_wdata  = ext_wdata_q;

    // buffers: address drives out during the processor's expansion bus cycle and in while another master owns the bus; data follows the cycle direction
    assign abuf_to_ext_oe = cpu_owns_bus && ext_req_q;
    assign dbuf_to_ext_oe = cpu_owns_bus && ext_req_q && ext_write_q;
    assign dbuf_to_cpu_oe = cpu_owns_bus && ext_req_q && !ext_write_q;
    assign abuf_to_cpu_oe = !cpu_owns_bus;
endmodule

// ===== testbench/dmc_cache_ctrl_checker.sv
// port assertions of the cache controller
`timescale 1ns/100ps
module dmc_cache_ctrl_checker
    import dmc_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ce,
    // processor side
    input wire logic       cycle_done_n,
    input wire dmc_word_t  cpu_data_out,
    // expansion bus
    input wire logic       ext_req,
    input wire logic       ext_write,
    input wire dmc_waddr_t ext_addr,
    input wire dmc_word_t  ext_wdata,
    input wire dmc_word_t  ext_rdata,
    input wire logic       ext_done,
    input wire logic       abuf_to_ext_oe,
    input wire logic       dbuf_to_ext_oe,
    // arbitration and status
    input wire logic [3:0] bus_req,
    input wire logic [3:0] bus_grant,
    input wire logic       cpu_owns_bus,
    input wire logic       sweep_busy
);
    logic [15:0] clk_cnt_q;

    // enabled clocks since reset, saturating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_cnt_q <= 16'h0000;
        end else if (ce && clk_cnt_q != 16'hFFFF) begin
            clk_cnt_q <= clk_cnt_q + 16'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_done_ends;
        $fell(cycle_done_n) |-> ##[1:2] cycle_done_n;
    endproperty
    a_done_ends: assert property (p_done_ends) else $error("cycle done held too long");
    property p_req_hold;
        ext_req && !ext_done |=> ext_req;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("bus request dropped early");
    property p_ext_stable;
        ext_req && !ext_done |=> $stable(ext_addr) && $stable(ext_write) && $stable(ext_wdata);
    endproperty
    a_ext_stable: assert property (p_ext_stable) else $error("bus cycle changed");
    property p_req_fall;
        $fell(ext_req) |-> $past(ext_done);
    endproperty
    a_req_fall: assert property (p_req_fall) else $error("request ended unanswered");
    property p_fill_data;
        ext_req && ext_done && !ext_write |=> cpu_data_out == $past(ext_rdata);
    endproperty
    a_fill_data: assert property (p_fill_data) else $error("fill data not passed on");
    property p_fill_done;
        ext_req && ext_done && !ext_write |-> ##[1:2] !cycle_done_n;
    endproperty
    a_fill_done: assert property (p_fill_done) else $error("fill not terminated");
    property p_grant_onehot;
        $onehot0(bus_grant) && (cpu_owns_bus == (bus_grant == 4'h0));
    endproperty
    a_grant_onehot: assert property (p_grant_onehot) else $error("grant not one-hot");
    property p_grant_cause;
        (bus_grant & ~$past(bus_req)) == 4'h0;
    endproperty
    a_grant_cause: assert property (p_grant_cause) else $error("grant without request");
    property p_idle_cpu;
        bus_req == 4'h0 ##1 bus_req == 4'h0 |-> cpu_owns_bus;
    endproperty
    a_idle_cpu: assert property (p_idle_cpu) else $error("bus not returned");
    property p_ext_owner;
        ext_req |-> cpu_owns_bus && abuf_to_ext_oe && (dbuf_to_ext_oe == ext_write);
    endproperty
    a_ext_owner: assert property (p_ext_owner) else $error("cycle without ownership");
    property p_sweep_len;
        $fell(sweep_busy) |-> clk_cnt_q >= 16'h3FFF && clk_cnt_q <= 16'h4001;
    endproperty
    a_sweep_len: assert property (p_sweep_len) else $error("sweep length wrong");

    c_fill: cover property (ext_req && ext_done && !ext_write);
    c_post: cover property (ext_req && ext_done && ext_write);
    c_grant: cover property (bus_grant == 4'h8);
endmodule

bind dmc_cache_ctrl dmc_cache_ctrl_checker dmc_cache_ctrl_checker_inst (
    .clk, .rst, .ce, .cycle_done_n, .cpu_data_out, .ext_req, .ext_write, .ext_addr,
    .ext_wdata, .ext_rdata, .ext_done, .bus_req, .bus_grant, .cpu_owns_bus, .sweep_busy,
    .abuf_to_ext_oe, .dbuf_to_ext_oe
);

// ===== testbench/dmc_ext_mem.sv
// expansion bus memory answering the controller's cycles
`timescale 1ns/100ps
module dmc_ext_mem
    import dmc_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // answer latency in clocks, at least 1
    input var int          lat,
    // expansion bus
    input wire logic       ext_req,
    input wire logic       ext_write,
    input wire dmc_waddr_t ext_addr,
    input wire dmc_be_t    ext_be_n,
    input wire dmc_word_t  ext_wdata,
    output dmc_word_t      ext_rdata,
    output logic           ext_done,
    // traffic counts
    output int             n_rd,
    output int             n_wr
);
    dmc_word_t mem [dmc_waddr_t];
    dmc_word_t cur;
    int        wait_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_done <= 1'b0;
            ext_rdata <= 32'h00000000;
            wait_q <= 0;
            n_rd <= 0;
            n_wr <= 0;
        end else begin
            ext_done <= 1'b0;
            // outside the answer the data lines wander
            ext_rdata <= ~ext_rdata;
            if (ext_req && !ext_done) begin
                wait_q <= wait_q + 1;
                if (wait_q + 1 >= lat) begin
                    wait_q <= 0;
                    ext_done <= 1'b1;
                    cur = mem.exists(ext_addr) ? mem[ext_addr] : {6'h2A, ext_addr};
                    if (ext_write) begin
                        for (int i = 0; i < BE_W; i++) begin
                            if (!ext_be_n[i]) cur[8*i +: 8] = ext_wdata[8*i +: 8];
                        end
                        mem[ext_addr] = cur;
                        n_wr <= n_wr + 1;
                    end else begin
                        ext_rdata <= cur;
                        n_rd <= n_rd + 1;
                    end
                end
            end
        end
    end
endmodule

// ===== testbench/dmc_cache_ctrl_tb.sv
// self-checking bench of the cache controller with an expansion memory model
`timescale 1ns/100ps
module dmc_cache_ctrl_tb;
    import dmc_pkg::*;
    logic       clk, rst, ce, cache_enable, shadow_bios, address_strobe_n, cpu_mem_io;
    logic       cpu_write, cpu_data_oe, cycle_done_n, ext_req, ext_write, ext_mem_io;
    logic       ext_done, snoop_write, cpu_owns_bus, sweep_busy, ph;
    logic [29:0] cpu_addr;
    logic [3:0] bus_req, bus_grant;
    dmc_be_t    byte_lane_enables_n, ext_be_n, snoop_be_n;
    dmc_word_t  cpu_data_in, cpu_data_out, ext_wdata, ext_rdata, snoop_data;
    dmc_waddr_t ext_addr, snoop_addr;
    int         bad_count, total_checks, lat, n_rd, n_wr, w, n0;
    localparam dmc_waddr_t A = 26'h0004C21;
    localparam dmc_waddr_t B = 26'h2004C21;
    localparam dmc_waddr_t D = 26'h0038000;
    localparam dmc_waddr_t C = 26'h0001234;

    dmc_cache_ctrl dmc_cache_ctrl_inst (
        .clk, .rst, .ce, .cache_enable, .shadow_bios, .cpu_addr, .byte_lane_enables_n,
        .address_strobe_n, .cpu_mem_io, .cpu_write, .cpu_data_in, .cpu_data_out, .cpu_data_oe,
        .cycle_done_n, .ext_req, .ext_write, .ext_mem_io, .ext_addr, .ext_be_n, .ext_wdata,
        .ext_rdata, .ext_done, .snoop_write, .snoop_addr, .snoop_be_n, .snoop_data, .bus_req,
        .bus_grant, .cpu_owns_bus, .abuf_to_ext_oe(), .abuf_to_cpu_oe(), .dbuf_to_ext_oe(),
        .dbuf_to_cpu_oe(), .sweep_busy
    );
    dmc_ext_mem dmc_ext_mem_inst (
        .clk, .rst, .lat, .ext_req, .ext_write, .ext_addr, .ext_be_n, .ext_wdata, .ext_rdata,
        .ext_done, .n_rd, .n_wr
    );

    always #10 clk = ~clk;
    // mirror of the bus clock phase: high means the next edge is a tick
    always @(posedge clk or posedge rst) begin
        if (rst) ph <= 1'b0;
        else ph <= ~ph;
    end

    task automatic chk(input string what, input dmc_word_t exp, input dmc_word_t got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_cycle(input dmc_waddr_t a, input logic wr, input logic mio,
                             input dmc_word_t d, output int waits, output dmc_word_t rd);
        @(negedge clk);
        while (ph) @(negedge clk);
        cpu_addr = {4'h0, a};
        cpu_write = wr;
        cpu_mem_io = mio;
        cpu_data_in = d;
        address_strobe_n = 1'b0;
        repeat (2) @(negedge clk);
        address_strobe_n = 1'b1;
        waits = 0;
        @(negedge clk);
        while (cycle_done_n !== 1'b0 && waits < 400) begin
            repeat (2) @(negedge clk);
            waits++;
        end
        chk("cycle done", 0, cycle_done_n);
        rd = cpu_data_out;
        if (!wr) chk("data enable", 1, cpu_data_oe);
        @(negedge clk);
    endtask

    task automatic rd(input dmc_waddr_t a, input dmc_word_t exp, input logic hit,
                      input logic mio = 1'b1);
        int        k;
        int        m;
        dmc_word_t v;
        m = n_rd;
        bus_cycle(a, 1'b0, mio, 32'h00000000, k, v);
        chk("read data", exp, v);
        chk("memory reads", hit ? m : m + 1, n_rd);
        if (hit) chk("hit waits", 0, k);
        else chk("miss stalls", 1, k > 0);
    endtask

    task automatic wr(input dmc_waddr_t a, input dmc_word_t d, output int k);
        dmc_word_t v;
        bus_cycle(a, 1'b1, 1'b1, d, k, v);
    endtask

    task automatic t_sweep();
        lat = 1;
        rd(A, {6'h2A, A}, 1'b0);
        for (int i = 0; i < 20000 && sweep_busy !== 1'b0; i++) @(negedge clk);
        chk("sweep busy", 0, sweep_busy);
        rd(A, {6'h2A, A}, 1'b0);
        $display("test sweep finished");
    endtask

    task automatic t_fill_hit();
        lat = 6;
        rd(C, {6'h2A, C}, 1'b0);
        rd(C, {6'h2A, C}, 1'b1);
        $display("test fill and hit finished");
    endtask

    task automatic t_write();
        n0 = n_wr;
        wr(A, 32'h13579BDF, w);
        chk("write hit waits", 1, w);
        rd(A, 32'h13579BDF, 1'b1);
        wr(B, 32'h2468ACE0, w);
        rd(A, 32'h13579BDF, 1'b1);
        rd(B, 32'h2468ACE0, 1'b0);
        chk("memory writes", n0 + 2, n_wr);
        rd(A, 32'h13579BDF, 1'b0);
        $display("test write finished");
    endtask

    task automatic t_snoop();
        @(negedge clk);
        snoop_addr = A;
        snoop_data = 32'hC0FFEE11;
        snoop_write = 1'b1;
        @(negedge clk);
        snoop_write = 1'b0;
        repeat (8) @(negedge clk);
        rd(A, 32'hC0FFEE11, 1'b1);
        $display("test snoop finished");
    endtask

    task automatic t_bios();
        shadow_bios = 1'b1;
        rd(D, {6'h2A, D}, 1'b0);
        rd(D, {6'h2A, D}, 1'b0);
        rd(A, 32'h13579BDF, 1'b0, 1'b0);
        $display("test uncached finished");
    endtask

    task automatic t_disable();
        cache_enable = 1'b0;
        rd(A, 32'h13579BDF, 1'b0);
        wr(A, 32'h0BADF00D, w);
        cache_enable = 1'b1;
        rd(A, 32'hC0FFEE11, 1'b1);
        $display("test disable finished");
    endtask

    task automatic t_arb();
        logic [3:0] rq [5] = '{4'h3, 4'h6, 4'hC, 4'h8, 4'h0};
        logic [3:0] ex [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
        repeat (20) @(negedge clk);
        for (int i = 0; i < 5; i++) begin
            bus_req = rq[i];
            repeat (3) @(negedge clk);
            chk("bus grant", ex[i], bus_grant);
            chk("cpu owner", ex[i] == 4'h0, cpu_owns_bus);
        end
        $display("test arbitration finished");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        cache_enable = 1'b1;
        shadow_bios = 1'b0;
        cpu_addr = 30'h00000000;
        byte_lane_enables_n = BE_ALL_N;
        address_strobe_n = 1'b1;
        cpu_mem_io = 1'b1;
        cpu_write = 1'b0;
        cpu_data_in = 32'h00000000;
        snoop_write = 1'b0;
        snoop_addr = 26'h0000000;
        snoop_be_n = BE_ALL_N;
        snoop_data = 32'h00000000;
        bus_req = 4'h0;
        lat = 1;
        bad_count = 0;
        total_checks = 0;
        repeat (10) @(negedge clk);
        chk("reset done", 1, cycle_done_n);
        chk("reset request", 0, ext_req);
        chk("reset sweep", 1, sweep_busy);
        rst = 1'b0;
        t_sweep();
        t_fill_hit();
        t_write();
        t_snoop();
        t_bios();
        t_disable();
        t_arb();
        results();
    end

    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        results();
    end
endmodule
